// ---- bench/fscond_ctrl_model.sv ----
// fscond_ctrl_model: controller side, output pull and lock cell
// assumes: rst stands for a power cycle of the device
`timescale 1ns/1ns
module fscond_ctrl_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // pull request and lock cell
    input  wire logic       want_high,
    input  wire logic [1:0] nv_lock_store_reg,
    output logic            out_pulled_up,
    output logic      [1:0] nv_lock_bits
);
    // pull-up asks for the high part, pull-down for the low part
    assign out_pulled_up = want_high;
    initial nv_lock_bits = 2'h0;
    // cell keeps written bits through power cycles and never clears
    always @(posedge core_clk) begin
        if (!rst) nv_lock_bits <= nv_lock_bits | nv_lock_store_reg;
    end
endmodule : fscond_ctrl_model

// ---- bench/fscond_top_props.sv ----
// fscond_top_props: port checker for fscond_top
// assumes: bound into every fscond_top instance
`timescale 1ns/1ns
module fscond_top_props
    import fscond_pkg::*;
(
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // command port
    input wire logic              cmd_valid,
    input wire logic              cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic              resp_valid_reg,
    // outputs and lock
    input wire logic [VAL_W-1:0]  dac_code_reg,
    input wire logic [1:0]        field_range_reg,
    input wire logic              filter_corner_reg,
    input wire logic [1:0]        nv_lock_bits,
    input wire logic [1:0]        nv_lock_store_reg
);
    // ****************
    // command tracking
    // ****************
    logic       boot_q;
    logic       lock_q;
    logic [7:0] mode_q;
    logic       tk;
    logic       twr;
    assign tk = cmd_valid && !boot_q && !lock_q;
    assign twr = tk && cmd_write;
    // boot cycle and engaged lock refuse commands
    always_ff @(posedge core_clk) begin
        boot_q <= rst;
        if (rst) begin
            lock_q <= 1'b0;
            mode_q <= MODE_RST;
        end else begin
            if (boot_q) lock_q <= nv_lock_bits[0];
            if (twr && cmd_addr == IDX_MODE) mode_q <= cmd_wdata[7:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (tk && !cmd_write |=> resp_valid_reg)
        else $error("read not answered");
    a_no_answer: assert property (!(tk && !cmd_write) |=> !resp_valid_reg)
        else $error("answer without taken read");
    a_range_follow: assert property (twr && cmd_addr == IDX_MODE
        |-> ##2 field_range_reg == mode_q[3:2]) else $error("range stale");
    a_filter_follow: assert property (twr && cmd_addr == IDX_MODE
        |-> ##2 filter_corner_reg == mode_q[4]) else $error("filter stale");
    a_plain_lsb: assert property (!mode_q[6] && !$past(mode_q[6])
        && !$past(mode_q[6], 2) |-> dac_code_reg[1:0] == 2'h0)
        else $error("plain output not 12 bit");
    a_mux_upper: assert property (mode_q[6] && $past(mode_q[6])
        && $past(mode_q[6], 2) |-> dac_code_reg[13:7] == 7'h00)
        else $error("part wider than 7 bits");
    a_lock_sticky: assert property ((nv_lock_store_reg
        & $past(nv_lock_store_reg)) == $past(nv_lock_store_reg))
        else $error("lock bit cleared");
    a_lock_or: assert property (twr && cmd_addr == IDX_LOCK |-> ##2
        nv_lock_store_reg == ($past(nv_lock_store_reg)
        | $past(cmd_wdata[1:0], 2))) else $error("lock write wrong");
    a_lock_frozen: assert property (lock_q |=> $stable(field_range_reg)
        && $stable(filter_corner_reg)) else $error("locked mode changed");
    c_read: cover property (tk && !cmd_write);
    c_lock: cover property (lock_q && cmd_valid);
    c_mux: cover property (mode_q[6] && dac_code_reg != 14'h0000);
endmodule : fscond_top_props

bind fscond_top fscond_top_props u_props (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .resp_valid_reg(resp_valid_reg), .dac_code_reg(dac_code_reg),
    .field_range_reg(field_range_reg),
    .filter_corner_reg(filter_corner_reg), .nv_lock_bits(nv_lock_bits),
    .nv_lock_store_reg(nv_lock_store_reg));

// ---- bench/test_field_signal_conditioning.sv ----
// test_field_signal_conditioning: command-port tests of fscond_top
// assumes: controller model supplies pull direction and lock cell
`timescale 1ns/1ns
module test_field_signal_conditioning;
    import fscond_pkg::*;
    logic        core_clk, rst, cmd_valid, cmd_write, field_valid, got;
    logic        want_high, resp_valid_reg, out_pulled_up, filter_corner_reg;
    logic [3:0]  cmd_addr;
    logic [15:0] cmd_wdata, resp_data_reg, d;
    logic [13:0] field_in, dac_code_reg, v;
    logic signed [7:0] temp_in;
    logic [1:0]  field_range_reg, nv_lock_bits, nv_lock_store_reg;
    int          num_errors, n_compared, cyc, n, nchg, r1, r2, g, o;
    fscond_top #(.REFRESH_CNT(64)) DUT (
        .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .resp_valid_reg(resp_valid_reg), .resp_data_reg(resp_data_reg),
        .field_in(field_in), .field_valid(field_valid), .temp_in(temp_in),
        .out_pulled_up(out_pulled_up), .dac_code_reg(dac_code_reg),
        .field_range_reg(field_range_reg),
        .filter_corner_reg(filter_corner_reg), .nv_lock_bits(nv_lock_bits),
        .nv_lock_store_reg(nv_lock_store_reg));
    fscond_ctrl_model u_ctrl (.core_clk(core_clk), .rst(rst),
        .want_high(want_high), .nv_lock_store_reg(nv_lock_store_reg),
        .out_pulled_up(out_pulled_up), .nv_lock_bits(nv_lock_bits));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end
    // ****************
    // tasks
    // ****************
    function automatic logic [13:0] rv(input logic [13:0] x);
        for (int i = 0; i < 14; i++) rv[i] = x[13-i];
    endfunction : rv
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        n_compared++;
        if (a !== e) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, a, e);
        end
    endtask : chk
    task automatic cmd(input logic w, input logic [3:0] a, input logic [15:0] x);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= x;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1;
        got = resp_valid_reg;
        d = resp_data_reg;
    endtask : cmd
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        cmd(1'b0, a, 16'h0000);
        chk({15'h0, got}, 16'h0001);
        chk(d, e);
    endtask : rc
    task automatic smp(input logic [13:0] f);
        @(posedge core_clk);
        field_in <= f;
        field_valid <= 1'b1;
        @(posedge core_clk);
        field_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : smp
    task automatic pv(input logic [13:0] f, input logic [13:0] e);
        smp(f);
        rc(IDX_VALUE, {2'h0, rv(e)});
    endtask : pv
    task automatic bstep(input logic [15:0] e);
        smp(14'h0000);
        cmd(1'b0, IDX_VALUE, 16'h0000);
        v = rv(d[13:0]);
        smp(14'h0000);
        cmd(1'b0, IDX_VALUE, 16'h0000);
        chk({2'h0, rv(d[13:0]) - v}, e);
    endtask : bstep
    task automatic pwr;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask : pwr
    task automatic close_out;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // ****************
    // sequence
    // ****************
    initial begin
        {cmd_valid, cmd_write, field_valid, want_high, rst} = 5'h01;
        {cmd_addr, cmd_wdata, field_in, temp_in} = '0;
        {num_errors, n_compared, cyc} = '0;
        pwr();
        rc(IDX_MODE, 16'(MODE_RST));
        rc(IDX_BAND, 16'(BAND_RST));
        rc(IDX_GAIN, 16'(GAIN_RST));
        rc(IDX_UPLIM, 16'(UPLIM_RST));
        rc(4'he, 16'h0000);
        for (n = 0; n < 4; n++) begin
            cmd(1'b1, IDX_BAND, 16'(n));
            rc(IDX_BAND, 16'(n));
        end
        cmd(1'b1, IDX_BAND, 16'h0001);
        pv(14'h2064, 14'h2064);
        cmd(1'b1, IDX_UPLIM, 16'h0100);
        pv(14'h23e8, 14'h2000);
        cmd(1'b1, IDX_UPLIM, 16'h01ff);
        cmd(1'b1, IDX_LOWLIM, 16'h0080);
        pv(14'h0000, 14'h1000);
        cmd(1'b1, IDX_LOWLIM, 16'h0000);
        cmd(1'b1, IDX_GAIN, 16'h3c00);
        pv(14'h2064, 14'h1f9c);
        cmd(1'b1, IDX_GAIN, 16'h1fff);
        cmd(1'b1, IDX_OFFSET, 16'h0600);
        pv(14'h3fff, 14'h1fff);
        cmd(1'b1, IDX_GAIN, 16'h0400);
        cmd(1'b1, IDX_OFFSET, 16'h0000);
        temp_in <= 8'sd10;
        pv(14'h3f40, 14'h1f47);
        chk({2'h0, dac_code_reg}, 16'h1f44);
        temp_in <= 8'sd0;
        cmd(1'b1, IDX_OFFSET, 16'h0200);
        smp(14'h2064);
        cmd(1'b1, IDX_MODE, 16'h0040);
        want_high <= 1'b1;
        repeat (70) @(posedge core_clk);
        #1 chk({2'h0, dac_code_reg}, 16'h0040);
        want_high <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk({2'h0, dac_code_reg}, 16'h0064);
        nchg = 0;
        v = dac_code_reg;
        for (n = 0; n < 140; n++) begin
            @(posedge core_clk);
            field_in <= 14'h2000 + 14'(n);
            field_valid <= 1'b1;
            #1 if (dac_code_reg !== v) nchg++;
            v = dac_code_reg;
        end
        field_valid <= 1'b0;
        chk({15'h0, nchg inside {2, 3}}, 16'h0001);
        cmd(1'b1, IDX_MODE, 16'h0080);
        bstep(16'h0001);
        cmd(1'b1, IDX_MODE, 16'h009c);
        bstep(16'h0002);
        chk({14'h0, field_range_reg}, 16'h0003);
        chk({15'h0, filter_corner_reg}, 16'h0001);
        cmd(1'b1, IDX_MODE, 16'h0000);
        // two-point calibration from readouts taken at the initial settings
        pv(14'h1000, 14'h1000);
        r1 = int'(rv(d[13:0]));
        pv(14'h3000, 14'h3000);
        r2 = int'(rv(d[13:0]));
        g = 12288 * 1024 / (r2 - r1);
        o = (14336 - (r2 - 8192) * g / 1024) / 16;
        cmd(1'b1, IDX_GAIN, 16'(g));
        cmd(1'b1, IDX_OFFSET, 16'(o));
        pv(14'h1000, 14'h0800);
        pv(14'h3000, 14'h3800);
        cmd(1'b1, IDX_GAIN, 16'h0400);
        cmd(1'b1, IDX_OFFSET, 16'h0200);
        cmd(1'b1, IDX_CIS0, 16'h1abc);
        rc(IDX_CIS0, 16'h0000);
        cmd(1'b1, IDX_MODE, 16'h0001);
        for (n = 0; n < 4; n++) begin
            cmd(1'b1, IDX_CIS0 + 4'(n), 16'h1aa0 + 16'(n));
            rc(IDX_CIS0 + 4'(n), 16'h1aa0 + 16'(n));
        end
        cmd(1'b1, IDX_LOCK, 16'h0002);
        rc(IDX_LOCK, 16'h0002);
        pwr();
        rc(IDX_MODE, 16'h0000);
        cmd(1'b1, IDX_LOCK, 16'h0001);
        cmd(1'b0, IDX_LOCK, 16'h0000);
        chk({15'h0, d[0]}, 16'h0001);
        rc(IDX_MODE, 16'h0000);
        pwr();
        cmd(1'b0, IDX_MODE, 16'h0000);
        chk({15'h0, got}, 16'h0000);
        cmd(1'b1, IDX_MODE, 16'h000c);
        pwr();
        cmd(1'b0, IDX_MODE, 16'h0000);
        chk({15'h0, got}, 16'h0000);
        close_out();
    end
endmodule : test_field_signal_conditioning

// ---- logic/fscond_path.sv ----
// fscond_path: gain, offset and limit processing with burn-in stimulus
// assumes: samples arrive as unsigned codes centred on mid-scale
`timescale 1ns/1ns
module fscond_path
    import fscond_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // settings and result
    fscond_path_if.path p
);

    logic [VAL_W-1:0] saw_reg, saw_next;
    logic [VAL_W-1:0] result_reg, result_next;

    always_comb begin
        logic signed [14:0] f;
        logic signed [13:0] g;
        logic signed [12:0] coef;
        logic signed [23:0] ppm;
        logic signed [38:0] gdelta;
        logic signed [15:0] geff;
        logic signed [31:0] prod;
        logic signed [17:0] sum;
        logic signed [17:0] lo;
        logic signed [17:0] hi;
        logic signed [17:0] off;
        f = '0; g = '0; coef = '0; ppm = '0; gdelta = '0; geff = '0;
        prod = '0; sum = '0; lo = '0; hi = '0; off = '0;
        saw_next    = saw_reg;
        result_next = result_reg;
        if (p.field_valid) begin
            // internal stimulus replaces the field in burn
            saw_next = saw_reg + (p.fast_saw ? SAW_STEP_FAST : SAW_STEP_SLOW);
            f = p.burn_in ? $signed({1'b0, saw_reg}) - $signed({1'b0, VAL_CENTER})
                          : $signed({1'b0, p.field})
                            - $signed({1'b0, VAL_CENTER});
            // band base plus linear step, then quadratic term
            coef = band_base(p.band)
                 + 13'(TC_STEP_PPM * int'(p.lin_tc));
            ppm = 24'(coef * p.temp)
                + 24'(QUADRATIC_TEMP_COEFF_STEP * int'(p.quad_tc) * p.temp * p.temp);
            g = $signed(p.gain);
            gdelta = 39'(g * ppm);
            geff = 16'(g) + 16'(gdelta >>> PPM_SHIFT);
            prod = 32'(f * geff);
            off = 18'($signed(p.offset)) <<< OFFSET_SHIFT;
            sum = 18'(prod >>> GAIN_SHIFT) + off;
            lo = 18'({p.low_lim, 5'h00});
            hi = 18'({p.up_lim, 5'h00});
            if (off < 0 && hi > off + 18'(VAL_MAX))
                hi = off + 18'(VAL_MAX);
            if (hi > 18'(VAL_MAX))
                hi = 18'(VAL_MAX);
            if (sum > hi)
                sum = hi;
            if (sum < lo)
                sum = lo;
            if (sum < 0)
                sum = '0;
            result_next = sum[VAL_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            saw_reg    <= '0;
            result_reg <= VAL_CENTER;
        end else begin
            saw_reg    <= saw_next;
            result_reg <= result_next;
        end
    end

    assign p.result = result_reg;

endmodule : fscond_path

// ---- logic/fscond_path_if.sv ----
// fscond_path_if: settings and samples from the register side to the path
// assumes: both ends on core_clk
`timescale 1ns/1ns
interface fscond_path_if;
    import fscond_pkg::*;
    logic        [1:0]        band;
    logic        [4:0]        lin_tc;
    logic        [2:0]        quad_tc;
    logic        [13:0]       gain;
    logic        [10:0]       offset;
    logic        [7:0]        low_lim;
    logic        [8:0]        up_lim;
    logic                     burn_in;
    logic                     fast_saw;
    logic        [VAL_W-1:0]  field;
    logic                     field_valid;
    logic signed [TEMP_W-1:0] temp;
    logic        [VAL_W-1:0]  result;

    modport cfg (output band, lin_tc, quad_tc, gain, offset, low_lim,
                 up_lim, burn_in, fast_saw, field, field_valid, temp,
                 input result);
    modport path (input band, lin_tc, quad_tc, gain, offset, low_lim,
                  up_lim, burn_in, fast_saw, field, field_valid, temp,
                  output result);
endinterface : fscond_path_if

// ---- logic/fscond_pkg.sv ----
// fscond_pkg: constants shared by the field signal conditioning block
// assumes: one 25 MHz clock, registers reached through a decoded command port
package fscond_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W  = 16;
    localparam int ADDR_W  = 4;
    localparam int VAL_W   = 14;
    localparam int PART_W  = 7;
    localparam int TEMP_W  = 8;
    localparam int CIS_W   = 13;
    localparam int CIS_N   = 4;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [3:0] IDX_MODE   = 4'h0;
    localparam logic [3:0] IDX_BAND   = 4'h1;
    localparam logic [3:0] IDX_LINTC  = 4'h2;
    localparam logic [3:0] IDX_QUADTC = 4'h3;
    localparam logic [3:0] IDX_GAIN   = 4'h4;
    localparam logic [3:0] IDX_OFFSET = 4'h5;
    localparam logic [3:0] IDX_LOWLIM = 4'h6;
    localparam logic [3:0] IDX_UPLIM  = 4'h7;
    localparam logic [3:0] IDX_CIS0   = 4'h8;
    localparam logic [3:0] IDX_LOCK   = 4'hc;
    localparam logic [3:0] IDX_VALUE  = 4'hd;

    // ****************************************
    // mode and lock register fields
    // ****************************************
    localparam int MODE_CIS_EN_BIT = 0;
    localparam int MODE_RANGE_LSB  = 2;
    localparam int MODE_FILTER_BIT = 4;
    localparam int MODE_FMT_LSB    = 6;
    localparam logic [1:0] FMT_PLAIN  = 2'h0;
    localparam logic [1:0] FMT_MUX    = 2'h1;
    localparam logic [1:0] FMT_BURNIN = 2'h2;
    localparam int LOCK_ENGAGE_BIT = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [1:0]  BAND_RST   = 2'h1;
    localparam logic [4:0]  LINTC_RST  = 5'h0f;
    localparam logic [2:0]  QUADTC_RST = 3'h1;
    localparam logic [13:0] GAIN_RST   = 14'h0400;
    localparam logic [10:0] OFFSET_RST = 11'h200;
    localparam logic [7:0]  LOWLIM_RST = 8'h00;
    localparam logic [8:0]  UPLIM_RST  = 9'h1ff;

    // ****************************************
    // processing scale
    // ****************************************
    localparam logic [13:0] VAL_CENTER   = 14'h2000;
    localparam logic [13:0] VAL_MAX      = 14'h3fff;
    localparam int GAIN_SHIFT   = 10;
    localparam int OFFSET_SHIFT = 4;
    localparam int LIMIT_SHIFT  = 5;
    localparam int PPM_SHIFT    = 20;
    localparam int TC_STEP_PPM  = 40;
    localparam int QUADRATIC_TEMP_COEFF_STEP    = 1;
    localparam logic [13:0] SAW_STEP_SLOW = 14'h0001;
    localparam logic [13:0] SAW_STEP_FAST = 14'h0002;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ           = 25;
    localparam int REFRESH_PERIOD_US = 2000;
    localparam int REFRESH_CYCLES    = REFRESH_PERIOD_US * CLK_MHZ;

    // band base coefficient in ppm/K
    function automatic logic signed [12:0] band_base(input logic [1:0] b);
        case (b)
            2'h0:    band_base = -13'sd3100;
            2'h2:    band_base = -13'sd1750;
            2'h1:    band_base = -13'sd500;
            default: band_base = 13'sd450;
        endcase
    endfunction : band_base

endpackage : fscond_pkg

// ---- logic/fscond_top.sv ----
// fscond_top: configuration set, lock and output formatting of the
// field signal conditioning block
// assumes: command port already deframed from supply modulation; the
// non-volatile lock bits are presented on nv_lock_bits at power-up
`timescale 1ns/1ns
module fscond_top
    import fscond_pkg::*;
#(
    parameter int REFRESH_CNT = REFRESH_CYCLES,
    parameter logic [CIS_N*CIS_W-1:0] CIS_INIT = '0
)(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // command port
    input  wire logic                     cmd_valid,
    input  wire logic                     cmd_write,
    input  wire logic [ADDR_W-1:0]        cmd_addr,
    input  wire logic [DATA_W-1:0]        cmd_wdata,
    output logic                          resp_valid_reg,
    output logic      [DATA_W-1:0]        resp_data_reg,
    // sensor samples
    input  wire logic [VAL_W-1:0]         field_in,
    input  wire logic                     field_valid,
    input  wire logic signed [TEMP_W-1:0] temp_in,
    // output pin direction sense and converter code
    input  wire logic                     out_pulled_up,
    output logic      [VAL_W-1:0]         dac_code_reg,
    // converter and filter settings
    output logic      [1:0]               field_range_reg,
    output logic                          filter_corner_reg,
    // non-volatile lock bits
    input  wire logic [1:0]               nv_lock_bits,
    output logic      [1:0]               nv_lock_store_reg
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]       mode_reg,   mode_next;
    logic [1:0]       band_reg,   band_next;
    logic [4:0]       lintc_reg,  lintc_next;
    logic [2:0]       quadtc_reg, quadtc_next;
    logic [13:0]      gain_reg,   gain_next;
    logic [10:0]      offset_reg, offset_next;
    logic [7:0]       lowlim_reg, lowlim_next;
    logic [8:0]       uplim_reg,  uplim_next;
    logic [CIS_W-1:0] cis_reg [CIS_N];
    logic [CIS_W-1:0] cis_next [CIS_N];
    logic [1:0]       lock_reg,   lock_next;
    logic             locked_reg, locked_next;
    logic             boot_reg,   boot_next;
    logic             rv_next;
    logic [DATA_W-1:0] rd_next;

    logic [1:0]       fmt;
    logic             wr_ok;
    logic [VAL_W-1:0] value;

    function automatic logic [VAL_W-1:0] rev_bits(input logic [VAL_W-1:0] v);
        for (int i = 0; i < VAL_W; i++)
            rev_bits[i] = v[VAL_W-1-i];
    endfunction : rev_bits

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0] idx);
        hit = (a == idx);
    endfunction : hit

    assign fmt   = mode_reg[MODE_FMT_LSB +: 2];
    // a locked device takes no command at all
    assign wr_ok = cmd_valid && cmd_write && !locked_reg;

    // ****************************************
    // register writes and reads
    // ****************************************
    always_comb begin
        mode_next   = mode_reg;
        band_next   = band_reg;
        lintc_next  = lintc_reg;
        quadtc_next = quadtc_reg;
        gain_next   = gain_reg;
        offset_next = offset_reg;
        lowlim_next = lowlim_reg;
        uplim_next  = uplim_reg;
        lock_next   = lock_reg;
        locked_next = locked_reg;
        boot_next   = 1'b0;
        cis_next    = cis_reg;
        rv_next     = 1'b0;
        rd_next     = '0;
        if (boot_reg) begin
            // lock takes effect only from the stored copy at power-up
            lock_next   = nv_lock_bits;
            locked_next = nv_lock_bits[LOCK_ENGAGE_BIT];
        end else if (wr_ok) begin
            if (hit(cmd_addr, IDX_MODE))   mode_next   = cmd_wdata[7:0];
            if (hit(cmd_addr, IDX_BAND))   band_next   = cmd_wdata[1:0];
            if (hit(cmd_addr, IDX_LINTC))  lintc_next  = cmd_wdata[4:0];
            if (hit(cmd_addr, IDX_QUADTC)) quadtc_next = cmd_wdata[2:0];
            if (hit(cmd_addr, IDX_GAIN))   gain_next   = cmd_wdata[13:0];
            if (hit(cmd_addr, IDX_OFFSET)) offset_next = cmd_wdata[10:0];
            if (hit(cmd_addr, IDX_LOWLIM)) lowlim_next = cmd_wdata[7:0];
            if (hit(cmd_addr, IDX_UPLIM))  uplim_next  = cmd_wdata[8:0];
            // set-only: nothing clears a lock bit once written
            if (hit(cmd_addr, IDX_LOCK))
                lock_next = lock_reg | cmd_wdata[1:0];
            for (int i = 0; i < CIS_N; i++)
                if (hit(cmd_addr, IDX_CIS0 + 4'(i))
                        && mode_reg[MODE_CIS_EN_BIT])
                    cis_next[i] = cmd_wdata[CIS_W-1:0];
        end
        if (!boot_reg && cmd_valid && !cmd_write && !locked_reg) begin
            rv_next = 1'b1;
            case (cmd_addr)
                IDX_MODE:   rd_next = DATA_W'(mode_reg);
                IDX_BAND:   rd_next = DATA_W'(band_reg);
                IDX_LINTC:  rd_next = DATA_W'(lintc_reg);
                IDX_QUADTC: rd_next = DATA_W'(quadtc_reg);
                IDX_GAIN:   rd_next = DATA_W'(gain_reg);
                IDX_OFFSET: rd_next = DATA_W'(offset_reg);
                IDX_LOWLIM: rd_next = DATA_W'(lowlim_reg);
                IDX_UPLIM:  rd_next = DATA_W'(uplim_reg);
                IDX_LOCK:   rd_next = DATA_W'(lock_reg);
                IDX_VALUE:  rd_next = DATA_W'(rev_bits(value));
                default: begin
                    rd_next = '0;
                    for (int i = 0; i < CIS_N; i++)
                        if (hit(cmd_addr, IDX_CIS0 + 4'(i)))
                            rd_next = DATA_W'(cis_reg[i]);
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg       <= MODE_RST;
            band_reg       <= BAND_RST;
            lintc_reg      <= LINTC_RST;
            quadtc_reg     <= QUADTC_RST;
            gain_reg       <= GAIN_RST;
            offset_reg     <= OFFSET_RST;
            lowlim_reg     <= LOWLIM_RST;
            uplim_reg      <= UPLIM_RST;
            lock_reg       <= '0;
            locked_reg     <= 1'b0;
            boot_reg       <= 1'b1;
            resp_valid_reg <= 1'b0;
            resp_data_reg  <= '0;
            for (int i = 0; i < CIS_N; i++)
                cis_reg[i] <= CIS_INIT[i*CIS_W +: CIS_W];
        end else begin
            mode_reg       <= mode_next;
            band_reg       <= band_next;
            lintc_reg      <= lintc_next;
            quadtc_reg     <= quadtc_next;
            gain_reg       <= gain_next;
            offset_reg     <= offset_next;
            lowlim_reg     <= lowlim_next;
            uplim_reg      <= uplim_next;
            lock_reg       <= lock_next;
            locked_reg     <= locked_next;
            boot_reg       <= boot_next;
            resp_valid_reg <= rv_next;
            resp_data_reg  <= rd_next;
            cis_reg        <= cis_next;
        end
    end

    // ****************************************
    // processing path
    // ****************************************
    fscond_path_if pif ();

    assign pif.band        = band_reg;
    assign pif.lin_tc      = lintc_reg;
    assign pif.quad_tc     = quadtc_reg;
    assign pif.gain        = gain_reg;
    assign pif.offset      = offset_reg;
    assign pif.low_lim     = lowlim_reg;
    assign pif.up_lim      = uplim_reg;
    assign pif.burn_in     = (fmt == FMT_BURNIN);
    assign pif.fast_saw    = mode_reg[MODE_FILTER_BIT];
    assign pif.field       = field_in;
    assign pif.field_valid = field_valid;
    assign pif.temp        = temp_in;
    assign value           = pif.result;

    fscond_path u_path (
        .core_clk (core_clk),
        .rst      (rst),
        .p        (pif.path)
    );

    // ****************************************
    // output formatting
    // ****************************************
    logic [31:0]      refresh_reg, refresh_next;
    logic [VAL_W-1:0] held_reg,    held_next;
    logic [VAL_W-1:0] dac_next;

    always_comb begin
        refresh_next = refresh_reg;
        held_next    = held_reg;
        // latched value refreshes once per refresh period
        if (refresh_reg >= 32'(REFRESH_CNT - 1)) begin
            refresh_next = '0;
            held_next    = value;
        end else begin
            refresh_next = refresh_reg + 32'h0000_0001;
        end
        case (fmt)
            FMT_PLAIN, FMT_BURNIN:
                // 12-bit converter code kept in the upper bits
                dac_next = {value[VAL_W-1:2], 2'h0};
            default:
                dac_next = out_pulled_up
                    ? VAL_W'(held_reg[VAL_W-1 -: PART_W])
                    : VAL_W'(held_reg[PART_W-1:0]);
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            refresh_reg       <= '0;
            held_reg          <= VAL_CENTER;
            dac_code_reg      <= VAL_CENTER;
            field_range_reg   <= '0;
            filter_corner_reg <= 1'b0;
            nv_lock_store_reg <= '0;
        end else begin
            refresh_reg       <= refresh_next;
            held_reg          <= held_next;
            dac_code_reg      <= dac_next;
            field_range_reg   <= mode_reg[MODE_RANGE_LSB +: 2];
            filter_corner_reg <= mode_reg[MODE_FILTER_BIT];
            nv_lock_store_reg <= lock_reg;
        end
    end

endmodule : fscond_top
